// >>> core/chan_evt_pkg.sv
// Shared constants and carriers for the channel event and descriptor ownership block
package chan_evt_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_EVENT    = 8'h00;
	localparam logic [7:0] REG_PAD_CNT  = 8'h04;
	localparam logic [7:0] REG_RX_BASE  = 8'h08;
	localparam logic [7:0] REG_REGION   = 8'h0c;
	localparam logic [7:0] REG_RX_STAT  = 8'h10;
	// Event register bit positions (interrupt entry bit 14, 15, 12 of 0..15 msb-first)
	localparam int EVT_TXB = 1;
	localparam int EVT_RXB = 0;
	localparam int EVT_RXF = 3;
	// Descriptor status word bit positions (field 0 is msb)
	localparam int DESC_E = 15;
	localparam int DESC_W = 13;
	localparam int DESC_I = 12;
	localparam int DESC_L = 11;
	// Descriptor spacing in bytes
	localparam logic [15:0] DESC_STRIDE = 16'h0008;
	// Reset values and counting constants
	localparam logic [15:0] EVENT_RST   = 16'h0000;
	localparam logic [7:0]  PAD_RST     = 8'h00;
	localparam logic [15:0] BASE_RST    = 16'h0000;
	localparam logic [15:0] OFFSET_RST  = 16'h0000;
	localparam logic [7:0]  PAD_ZERO    = 8'h00;
	localparam logic [7:0]  PAD_ONE     = 8'h01;
	localparam logic [1:0]  SLOT_ZERO   = 2'h0;
	localparam logic [1:0]  SLOT_ONE    = 2'h1;
	localparam logic [1:0]  SLOT_TWO    = 2'h2;
	// AXI responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {TX_DATA, TX_CLOSE, TX_PAD} tx_kind_e;

	typedef struct packed {
		tx_kind_e   kind;
		logic [7:0] data;
	} tx_char_s;

	typedef struct packed {
		logic last;
		logic error;
	} rx_done_s;

	typedef struct packed {
		logic        we;
		logic [31:0] addr;
		logic [15:0] wdata;
	} mem_req_s;
endpackage

// >>> core/channel_event_bd_ownership.sv
// Channel buffer-done events and receive descriptor ownership handling
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
module channel_event_bd_ownership
(
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rstn,
	// AXI4-Lite slave
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// Transmit characters from the channel
	input  wire chan_evt_pkg::tx_char_s   tx_in,
	input  wire logic                     tx_in_valid,
	output logic                          tx_in_ready,
	// Transmit FIFO side
	output chan_evt_pkg::tx_char_s        tx_fifo,
	output logic                          tx_fifo_valid,
	input  wire logic                     tx_fifo_ready,
	output logic                          tx_irq_req,
	// Receiver buffer completion
	input  wire chan_evt_pkg::rx_done_s   rx_done,
	input  wire logic                     rx_done_valid,
	output logic                          rx_done_ready,
	output logic                          rx_no_buffer,
	// Descriptor memory port
	output chan_evt_pkg::mem_req_s        mem_req,
	output logic                          mem_valid,
	input  wire logic                     mem_ack,
	input  wire logic [15:0]              mem_rdata
);

	typedef enum {RX_FETCH, RX_WAIT_FETCH, RX_OWNED, RX_NOBUF, RX_WRITE, RX_WAIT_WRITE} rx_state_e;
	// Local names for the package carriers
	typedef chan_evt_pkg::tx_char_s tx_char_s;
	typedef chan_evt_pkg::rx_done_s rx_done_s;
	typedef chan_evt_pkg::mem_req_s mem_req_s;

	// Byte-lane merge, used for every writable register except the pad count
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		merge16 = old;
		if (st[0])
			merge16[7:0] = wd[7:0];
		if (st[1])
			merge16[15:8] = wd[15:8];
	endfunction

	// Register state
	logic [15:0] event_reg, next_event_reg;
	logic [7:0]  pad_cnt, next_pad_cnt;
	logic [15:0] rx_base, next_rx_base;
	logic [15:0] region, next_region;
	// Bus state
	logic        awready_q, next_awready, arready_q, next_arready;
	logic        bvalid_q, next_bvalid, rvalid_q, next_rvalid;
	logic [1:0]  bresp_q, next_bresp, rresp_q, next_rresp;
	logic [31:0] rdata_q, next_rdata;
	// Transmit buffer and pad tracking
	tx_char_s    slot [2];
	tx_char_s    next_slot [2];
	logic [1:0]  fill, next_fill;
	logic        in_ready_q, next_in_ready;
	logic        armed, next_armed;
	logic [7:0]  pads_seen, next_pads_seen;
	logic        irq_q, next_irq;
	logic        tx_done_set;
	logic        out_valid_q, next_out_valid;
	// Receive descriptor walk
	rx_state_e   rx_state, next_rx_state;
	logic [15:0] rx_offset, next_rx_offset;
	logic [15:0] cur_status, next_cur_status;
	rx_done_s    done_q, next_done_q;
	logic        done_ready_q, next_done_ready;
	mem_req_s    mreq_q, next_mreq;
	logic        mvalid_q, next_mvalid;
	logic        rxb_set, rxf_set;
	logic        nobuf_q, next_nobuf;

	logic wr_go, rd_go, in_take, out_take;
	assign wr_go    = s_axi_awvalid && s_axi_wvalid && !bvalid_q && !awready_q;
	assign rd_go    = s_axi_arvalid && !rvalid_q && !arready_q;
	assign in_take  = tx_in_valid && in_ready_q;
	assign out_take = tx_fifo_valid && tx_fifo_ready;

	// Register file and AXI4-Lite handshakes; hardware set beats software clear
	always_comb
	begin
		next_event_reg = event_reg;
		next_pad_cnt   = pad_cnt;
		next_rx_base   = rx_base;
		next_region    = region;
		next_awready   = wr_go;
		next_arready   = rd_go;
		// Response only after the address and data handshake edge
		next_bvalid    = (bvalid_q && !s_axi_bready) || awready_q;
		next_bresp     = bresp_q;
		next_rvalid    = (rvalid_q && !s_axi_rready) || arready_q;
		next_rresp     = rresp_q;
		next_rdata     = rdata_q;
		if (wr_go)
		begin
			next_bresp  = chan_evt_pkg::RESP_OKAY;
			unique case (s_axi_awaddr)
				chan_evt_pkg::REG_EVENT:
					next_event_reg = event_reg & ~merge16(16'h0000, s_axi_wdata, s_axi_wstrb);
				chan_evt_pkg::REG_PAD_CNT:
					if (s_axi_wstrb[0])
						next_pad_cnt = s_axi_wdata[7:0];
				chan_evt_pkg::REG_RX_BASE:
					next_rx_base = merge16(rx_base, s_axi_wdata, s_axi_wstrb);
				chan_evt_pkg::REG_REGION:
					next_region = merge16(region, s_axi_wdata, s_axi_wstrb);
				chan_evt_pkg::REG_RX_STAT:
					next_bresp = chan_evt_pkg::RESP_OKAY;
				default:
					next_bresp = chan_evt_pkg::RESP_SLVERR;
			endcase
		end
		if (tx_done_set)
			next_event_reg[chan_evt_pkg::EVT_TXB] = 1'b1;
		if (rxb_set)
			next_event_reg[chan_evt_pkg::EVT_RXB] = 1'b1;
		if (rxf_set)
			next_event_reg[chan_evt_pkg::EVT_RXF] = 1'b1;
		if (rd_go)
		begin
			next_rresp  = chan_evt_pkg::RESP_OKAY;
			next_rdata  = 32'h0000_0000;
			unique case (s_axi_araddr)
				chan_evt_pkg::REG_EVENT:   next_rdata[15:0] = event_reg;
				chan_evt_pkg::REG_PAD_CNT: next_rdata[7:0]  = pad_cnt;
				chan_evt_pkg::REG_RX_BASE: next_rdata[15:0] = rx_base;
				chan_evt_pkg::REG_REGION:  next_rdata[15:0] = region;
				chan_evt_pkg::REG_RX_STAT: next_rdata = {rx_offset, 15'h0000, rx_no_buffer};
				default:                   next_rresp = chan_evt_pkg::RESP_SLVERR;
			endcase
		end
	end


	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			event_reg <= chan_evt_pkg::EVENT_RST;
			pad_cnt   <= chan_evt_pkg::PAD_RST;
			rx_base   <= chan_evt_pkg::BASE_RST;
			region    <= chan_evt_pkg::BASE_RST;
			awready_q <= 1'b0;
			arready_q <= 1'b0;
			bvalid_q  <= 1'b0;
			rvalid_q  <= 1'b0;
			bresp_q   <= chan_evt_pkg::RESP_OKAY;
			rresp_q   <= chan_evt_pkg::RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
		end
		else
		begin
			event_reg <= next_event_reg;
			pad_cnt   <= next_pad_cnt;
			rx_base   <= next_rx_base;
			region    <= next_region;
			awready_q <= next_awready;
			arready_q <= next_arready;
			bvalid_q  <= next_bvalid;
			rvalid_q  <= next_rvalid;
			bresp_q   <= next_bresp;
			rresp_q   <= next_rresp;
			rdata_q   <= next_rdata;
		end
	end

	// Two-slot buffer toward the FIFO; pads are counted as they enter the FIFO
	always_comb
	begin
		next_slot[0]   = slot[0];
		next_slot[1]   = slot[1];
		next_fill      = fill;
		next_armed     = armed;
		next_pads_seen = pads_seen;
		tx_done_set    = 1'b0;
		if (out_take)
		begin
			next_slot[0] = slot[1];
			next_fill    = fill - chan_evt_pkg::SLOT_ONE;
			if (slot[0].kind == chan_evt_pkg::TX_CLOSE)
			begin
				// Pad count moves the event later than the closing flag
				if (pad_cnt == chan_evt_pkg::PAD_ZERO)
					tx_done_set = 1'b1;
				else
				begin
					next_armed     = 1'b1;
					next_pads_seen = chan_evt_pkg::PAD_ZERO;
				end
			end
			else if (slot[0].kind == chan_evt_pkg::TX_PAD && armed)
			begin
				next_pads_seen = pads_seen + chan_evt_pkg::PAD_ONE;
				if (pads_seen + chan_evt_pkg::PAD_ONE == pad_cnt)
				begin
					tx_done_set = 1'b1;
					next_armed  = 1'b0;
				end
			end
		end
		if (in_take)
		begin
			next_slot[next_fill[0]] = tx_in;
			next_fill = next_fill + chan_evt_pkg::SLOT_ONE;
		end
		// Registered ready costs one slot of lookahead, hence two entries
		next_in_ready = (next_fill != chan_evt_pkg::SLOT_TWO);
		next_out_valid = (next_fill != chan_evt_pkg::SLOT_ZERO);
		next_irq      = tx_done_set;
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			slot[0]    <= '0;
			slot[1]    <= '0;
			fill       <= chan_evt_pkg::SLOT_ZERO;
			in_ready_q <= 1'b0;
			out_valid_q <= 1'b0;
			armed      <= 1'b0;
			pads_seen  <= chan_evt_pkg::PAD_ZERO;
			irq_q      <= 1'b0;
		end
		else
		begin
			slot[0]    <= next_slot[0];
			slot[1]    <= next_slot[1];
			fill       <= next_fill;
			in_ready_q <= next_in_ready;
			out_valid_q <= next_out_valid;
			armed      <= next_armed;
			pads_seen  <= next_pads_seen;
			irq_q      <= next_irq;
		end
	end

	// Receive descriptor walk: fetch, own, write back with ownership cleared
	always_comb
	begin
		next_rx_state   = rx_state;
		next_rx_offset  = rx_offset;
		next_cur_status = cur_status;
		next_done_q     = done_q;
		next_done_ready = 1'b0;
		next_nobuf      = nobuf_q;
		next_mreq       = mreq_q;
		next_mvalid     = mvalid_q && !mem_ack;
		rxb_set         = 1'b0;
		rxf_set         = 1'b0;
		unique case (rx_state)
			RX_FETCH:
			begin
				next_mvalid   = 1'b1;
				next_mreq.we  = 1'b0;
				next_mreq.addr = {region, rx_base + rx_offset};
				next_rx_state = RX_WAIT_FETCH;
			end
			RX_WAIT_FETCH:
				if (mem_ack)
				begin
					next_cur_status = mem_rdata;
					// Stays up through refetches until the host hands one back
					next_nobuf = !mem_rdata[chan_evt_pkg::DESC_E];
					// Cleared ownership means the host still holds it
					next_rx_state = mem_rdata[chan_evt_pkg::DESC_E] ? RX_OWNED : RX_NOBUF;
				end
			RX_OWNED:
			begin
				next_done_ready = !(rx_done_valid && done_ready_q);
				if (rx_done_valid && done_ready_q)
				begin
					next_done_q   = rx_done;
					next_rx_state = RX_WRITE;
				end
			end
			RX_NOBUF:
				// Poll again only when a completion is waiting, to spare the bus
				if (rx_done_valid)
					next_rx_state = RX_FETCH;
			RX_WRITE:
			begin
				next_mvalid    = 1'b1;
				next_mreq.we   = 1'b1;
				next_mreq.addr = {region, rx_base + rx_offset};
				next_mreq.wdata = cur_status;
				next_mreq.wdata[chan_evt_pkg::DESC_E] = 1'b0;
				next_mreq.wdata[chan_evt_pkg::DESC_L] = done_q.last || done_q.error;
				next_rx_state  = RX_WAIT_WRITE;
			end
			RX_WAIT_WRITE:
				if (mem_ack)
				begin
					rxb_set = cur_status[chan_evt_pkg::DESC_I];
					rxf_set = cur_status[chan_evt_pkg::DESC_I] && (done_q.last || done_q.error);
					if (cur_status[chan_evt_pkg::DESC_W])
						next_rx_offset = chan_evt_pkg::OFFSET_RST;
					else
						next_rx_offset = rx_offset + chan_evt_pkg::DESC_STRIDE;
					next_rx_state = RX_FETCH;
				end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			rx_state     <= RX_FETCH;
			rx_offset    <= chan_evt_pkg::OFFSET_RST;
			cur_status   <= 16'h0000;
			done_q       <= '0;
			done_ready_q <= 1'b0;
			nobuf_q      <= 1'b0;
			mreq_q       <= '0;
			mvalid_q     <= 1'b0;
		end
		else
		begin
			rx_state     <= next_rx_state;
			rx_offset    <= next_rx_offset;
			cur_status   <= next_cur_status;
			done_q       <= next_done_q;
			done_ready_q <= next_done_ready;
			nobuf_q      <= next_nobuf;
			mreq_q       <= next_mreq;
			mvalid_q     <= next_mvalid;
		end
	end

	// Registered outputs
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = awready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign tx_in_ready   = in_ready_q;
	assign tx_fifo       = slot[0];
	assign tx_fifo_valid = out_valid_q;
	assign tx_irq_req    = irq_q;
	assign rx_done_ready = done_ready_q;
	assign rx_no_buffer  = nobuf_q;
	assign mem_req       = mreq_q;
	assign mem_valid     = mvalid_q;

endmodule

// >>> bench/chan_evt_asserts.sv
// Port checks for the channel event and descriptor ownership block
`timescale 1ns/100ps
module chan_evt_asserts
(
	// Clock and reset
	input wire logic                   mclk,
	input wire logic                   rstn,
	// Transmit side
	input wire chan_evt_pkg::tx_char_s tx_fifo,
	input wire logic                   tx_fifo_valid,
	input wire logic                   tx_fifo_ready,
	input wire logic                   tx_irq_req,
	// Receive and descriptor side
	input wire chan_evt_pkg::rx_done_s rx_done,
	input wire logic                   rx_done_valid,
	input wire logic                   rx_done_ready,
	input wire logic                   rx_no_buffer,
	input wire chan_evt_pkg::mem_req_s mem_req,
	input wire logic                   mem_valid,
	input wire logic                   mem_ack
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Done request: one pulse, only after a closing or pad char left
	irq_pulse_a: assert property (tx_irq_req |=> !tx_irq_req)
		else $error("tx done request held over one cycle");
	irq_cause_a: assert property (tx_irq_req |-> $past(tx_fifo_valid && tx_fifo_ready
		&& tx_fifo.kind != chan_evt_pkg::TX_DATA)) else $error("tx done without close or pad");
	// A stalled head must not change, or a word is lost
	fifo_hold_a: assert property (tx_fifo_valid && !tx_fifo_ready |=> tx_fifo_valid
		&& $stable(tx_fifo)) else $error("tx head changed while stalled");
	// Descriptor requests hold still, so the region cannot drift mid-access
	mem_hold_a: assert property (mem_valid && !mem_ack |=> mem_valid && $stable(mem_req))
		else $error("descriptor request changed before ack");
	own_clear_a: assert property (mem_valid && mem_req.we |->
		!mem_req.wdata[chan_evt_pkg::DESC_E]) else $error("write back kept ownership");
	no_take_a: assert property (rx_no_buffer |-> !rx_done_ready)
		else $error("completion offered without buffer");
	write_after_a: assert property (rx_done_valid && rx_done_ready |-> ##[1:3]
		(mem_valid && mem_req.we)) else $error("no write back after completion");
	last_mark_a: assert property (rx_done_valid && rx_done_ready &&
		(rx_done.last || rx_done.error) |-> ##[1:3] (mem_valid && mem_req.we &&
		mem_req.wdata[chan_evt_pkg::DESC_L])) else $error("frame end not marked last");
endmodule

bind channel_event_bd_ownership chan_evt_asserts chk_u (.mclk, .rstn, .tx_fifo,
	.tx_fifo_valid, .tx_fifo_ready, .tx_irq_req, .rx_done, .rx_done_valid,
	.rx_done_ready, .rx_no_buffer, .mem_req, .mem_valid, .mem_ack);

// >>> bench/desc_mem_model.sv
// Descriptor memory shared with the host, prompt or slow
`timescale 1ns/100ps
module desc_mem_model
(
	// Clock
	input wire logic                   mclk,
	// Descriptor port
	input wire chan_evt_pkg::mem_req_s mem_req,
	input wire logic                   mem_valid,
	output logic                       mem_ack,
	output logic [15:0]                mem_rdata
);
	logic [15:0] mem [256];
	int          slow = 0;
	int          cnt = 0;
	initial
	begin
		foreach (mem[i]) mem[i] = 16'h0000;
		mem_ack = 1'b0;
		mem_rdata = 16'h0000;
	end
	// Answer after slow idle cycles; outside an ack the data bus toggles
	always @(posedge mclk)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_valid && !mem_ack && cnt < slow)
			cnt <= cnt + 1;
		else if (mem_valid && !mem_ack)
		begin
			cnt <= 0;
			mem_ack <= 1'b1;
			if (mem_req.we)
				mem[mem_req.addr[10:3]] <= mem_req.wdata;
			else
				mem_rdata <= mem[mem_req.addr[10:3]];
		end
	end
endmodule

// >>> bench/channel_event_bd_ownership_bench.sv
// Self-checking bench for the channel event and descriptor ownership block
`timescale 1ns/100ps
module channel_event_bd_ownership_bench;
	logic                   mclk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic                   s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic                   s_axi_arready, s_axi_rvalid, s_axi_rready, tx_in_valid;
	logic                   tx_in_ready, tx_fifo_valid, tx_fifo_ready, tx_irq_req;
	logic                   rx_done_valid, rx_done_ready, rx_no_buffer, mem_valid, mem_ack;
	logic [7:0]             s_axi_awaddr, s_axi_araddr;
	logic [31:0]            s_axi_wdata, s_axi_rdata, d;
	logic [3:0]             s_axi_wstrb;
	logic [1:0]             s_axi_bresp, s_axi_rresp, r;
	logic [15:0]            mem_rdata, hi;
	chan_evt_pkg::tx_char_s tx_in, tx_fifo, q[$];
	chan_evt_pkg::rx_done_s rx_done;
	chan_evt_pkg::mem_req_s mem_req;
	int                     err_total, checks, takes, irqs, irq_at, t0, n;
	logic [7:0]             outq[$];
	typedef struct {logic [7:0] pad; int at;} row_s;
	row_s                   rows [3] = '{'{8'h00, 2}, '{8'h01, 3}, '{8'h03, 5}};

	channel_event_bd_ownership dut_u (.*);
	desc_mem_model mem_u (.mclk, .mem_req, .mem_valid, .mem_ack, .mem_rdata);

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Both channels offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
		do
		begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge mclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		do
		begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask
	function automatic chan_evt_pkg::tx_char_s ch(chan_evt_pkg::tx_kind_e k, logic [7:0] v);
		return '{kind: k, data: v};
	endfunction
	// Valid held across the list, payload moved on after each take
	task automatic send();
		@(posedge mclk);
		foreach (q[i])
		begin
			tx_in <= q[i];
			tx_in_valid <= 1'b1;
			do @(posedge mclk); while (tx_in_ready !== 1'b1);
		end
		tx_in_valid <= 1'b0;
	endtask
	// One completion, then wait for its write back to land
	task automatic rxc(input logic l, input logic e);
		@(posedge mclk);
		rx_done <= '{last: l, error: e};
		rx_done_valid <= 1'b1;
		do @(posedge mclk); while (rx_done_ready !== 1'b1);
		rx_done_valid <= 1'b0;
		do @(posedge mclk); while (!(mem_valid && mem_ack && mem_req.we));
		repeat (3) @(posedge mclk);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Port monitor: fifo takes, done pulses, descriptor region
	always @(posedge mclk)
	begin
		if (tx_irq_req === 1'b1) {irq_at, irqs} = {takes, irqs + 1};
		if (tx_fifo_valid && tx_fifo_ready)
		begin
			takes++;
			outq.push_back(tx_fifo.data);
		end
		if (mem_valid) hi = mem_req.addr[31:16];
	end
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Run is a few hundred cycles; this is 20000 cycles, well above that
	initial
	begin
		#200000;
		err_total++;
		conclude();
	end
	initial
	begin
		{rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
		{tx_in, tx_in_valid, tx_fifo_ready, rx_done, rx_done_valid} = {10'h0, 2'h1, 3'h0};
		{err_total, checks, takes, irqs, irq_at} = '0;
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		axr(chan_evt_pkg::REG_PAD_CNT);
		chk("pad reset", d, 32'h0);
		axr(8'h14);
		chk("bad read", r, chan_evt_pkg::RESP_SLVERR);
		axw(8'h14, 32'h1);
		chk("bad write", r, chan_evt_pkg::RESP_SLVERR);
		$display("reset test done");
		foreach (rows[i])
		begin
			axw(chan_evt_pkg::REG_PAD_CNT, {24'h0, rows[i].pad});
			{t0, n} = {takes, irqs};
			q = {ch(chan_evt_pkg::TX_DATA, 8'h5a), ch(chan_evt_pkg::TX_CLOSE, 8'h7e)};
			repeat (rows[i].pad) q.push_back(ch(chan_evt_pkg::TX_PAD, 8'h7e));
			send();
			repeat (8) @(posedge mclk);
			chk("done at", irq_at - t0, rows[i].at);
			chk("done count", irqs - n, 1);
			axr(chan_evt_pkg::REG_EVENT);
			chk("tx done", d, 32'h2);
			axw(chan_evt_pkg::REG_EVENT, 32'h2);
			axr(chan_evt_pkg::REG_EVENT);
			chk("tx clear", d, 32'h0);
			$display("tx row %0d done", i);
		end
		// Stall the fifo until the buffer refuses, then drain in order
		tx_fifo_ready <= 1'b0;
		n = takes;
		q = {ch(chan_evt_pkg::TX_DATA, 8'ha1), ch(chan_evt_pkg::TX_DATA, 8'ha2)};
		q.push_back(ch(chan_evt_pkg::TX_DATA, 8'ha3));
		fork
			send();
			begin
				repeat (10) @(posedge mclk);
				chk("held head", tx_fifo.data, 8'ha1);
				chk("refused", {tx_in_ready, 8'(takes - n)}, 9'h0);
				tx_fifo_ready <= 1'b1;
			end
		join
		repeat (6) @(posedge mclk);
		chk("drain", {outq[$-2], outq[$-1], outq[$], tx_fifo_valid}, 25'h1434546);
		$display("buffer test done");
		// Two descriptors at base 0x10 in region 0x1234, second wraps
		axw(chan_evt_pkg::REG_RX_BASE, 32'h10);
		axw(chan_evt_pkg::REG_REGION, 32'h1234);
		{mem_u.mem[2], mem_u.mem[3]} = {16'h9000, 16'ha000};
		rxc(1'b1, 1'b0);
		chk("region", hi, 16'h1234);
		chk("first closed", mem_u.mem[2], 16'h1800);
		axr(chan_evt_pkg::REG_EVENT);
		chk("rx done", d, 32'h9);
		axw(chan_evt_pkg::REG_EVENT, 32'h9);
		mem_u.slow = 3;
		rxc(1'b0, 1'b1);
		chk("abort closed", mem_u.mem[3], 16'h2800);
		axr(chan_evt_pkg::REG_EVENT);
		chk("rx masked", d, 32'h0);
		repeat (10) @(posedge mclk);
		axr(chan_evt_pkg::REG_RX_STAT);
		chk("wrapped", d, 32'h1);
		fork
			rxc(1'b0, 1'b0);
			begin
				repeat (20) @(posedge mclk);
				chk("skip cleared", {rx_done_ready, rx_no_buffer, mem_u.mem[2]}, 18'h11800);
				@(negedge mclk) mem_u.mem[2] = 16'h9000;
			end
		join
		chk("reused base", mem_u.mem[2], 16'h1000);
		axr(chan_evt_pkg::REG_EVENT);
		chk("rx done again", d, 32'h1);
		$display("rx test done");
		// Reset in mid-run puts the registers back to zero
		axw(chan_evt_pkg::REG_PAD_CNT, 32'h5);
		rstn <= 1'b0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		axr(chan_evt_pkg::REG_PAD_CNT);
		chk("pad after reset", d, 32'h0);
		axr(chan_evt_pkg::REG_RX_BASE);
		chk("base after reset", d, 32'h0);
		$display("mid reset test done");
		conclude();
	end
endmodule
